//--- pri_irq_pkg.sv
// constants, register map and helpers shared by both ends of the link
package pri_irq_pkg;

    // ****************************************************
    // widths
    // ****************************************************
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam int LEVEL_W = 4;
    localparam int NUM_LINES = 5;
    localparam int SEL_W = 3;
    localparam int IO_ADDR_W = 2;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int IDENT_WAIT_NS = 1000;
    // longest wait rounds down
    localparam int IDENT_WAIT_CYC = IDENT_WAIT_NS / CLK_PERIOD_NS;
    localparam int WAIT_CNT_W = 8;

    // ****************************************************
    // processor side register map
    // ****************************************************
    localparam logic [ADDR_W-1:0] A_LEVEL_ENABLE = 4'h0;
    localparam logic [ADDR_W-1:0] A_LEVEL_DETECT = 4'h1;
    localparam logic [ADDR_W-1:0] A_CURRENT_LEVEL = 4'h2;
    localparam logic [ADDR_W-1:0] A_INT_ENABLE = 4'h3;
    localparam logic [ADDR_W-1:0] A_INT_DETECT = 4'h4;
    localparam logic [ADDR_W-1:0] A_SYS_CTRL = 4'h5;
    localparam logic [ADDR_W-1:0] A_IDENT_CMD = 4'h6;
    localparam logic [ADDR_W-1:0] A_ACCUM = 4'h7;
    localparam logic [ADDR_W-1:0] A_CAUSE_CODE = 4'h8;
    localparam logic [ADDR_W-1:0] A_PARITY_STAT = 4'h9;
    localparam logic [ADDR_W-1:0] A_PARITY_ADDR = 4'hA;

    // ****************************************************
    // levels and bit positions
    // ****************************************************
    localparam logic [LEVEL_W-1:0] LVL_IDENT_MIN = 4'hA;
    localparam logic [LEVEL_W-1:0] LVL_IDENT_MAX = 4'hD;
    localparam int LVL_INTERNAL = 14;
    localparam int ERR_IND_BIT = 5;
    localparam int SYS_ON_BIT = 0;
    localparam int PAR_FAULT_BIT = 0;

    // ****************************************************
    // interface side register map and bits
    // ****************************************************
    localparam logic [IO_ADDR_W-1:0] A_IO_CTRL = 2'h0;
    localparam logic [IO_ADDR_W-1:0] A_IO_STATUS = 2'h1;
    localparam int CTL_EOP_EN_BIT = 0;
    localparam int CTL_ERR_EN_BIT = 1;
    localparam int ST_READY_BIT = 3;
    localparam int ST_ERROR_BIT = 4;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
    localparam logic [LEVEL_W-1:0] RST_LEVEL = 4'h0;

    // search sequencer states
    typedef enum logic [2:0]
    {
        ID_IDLE = 3'b001,
        ID_PRESENT = 3'b010,
        ID_PULSE = 3'b100
    } ident_state_t;

    // level carried by each hardware request line
    function automatic logic [LEVEL_W-1:0] line_level(
        input logic [SEL_W-1:0] idx);
        case (idx)
            3'h0: line_level = 4'hA;
            3'h1: line_level = 4'hB;
            3'h2: line_level = 4'hC;
            3'h3: line_level = 4'hD;
            default: line_level = 4'hF;
        endcase
    endfunction

endpackage

//--- pri_irq_bus_if.sv
// bus wires between the processor end and one i/o interface slot
`timescale 1ns/10ps
`default_nettype none
interface pri_irq_bus_if;
    import pri_irq_pkg::*;

    // request lines, index 0..4 = levels 10, 11, 12, 13, 15
    logic [NUM_LINES-1:0] irq_lines;
    // search level presented to all slots
    logic [LEVEL_W-1:0] search_level;
    logic search_present;
    // head of the search daisy chain
    logic search_chain_pulse;
    // answer from the slot that stopped the chain
    logic ident_ack;
    logic [WORD_W-1:0] ident_code;

    modport cpu
    (
        input irq_lines,
        input ident_ack,
        input ident_code,
        output search_level,
        output search_present,
        output search_chain_pulse
    );

    modport io
    (
        output irq_lines,
        output ident_ack,
        output ident_code,
        input search_level,
        input search_present,
        input search_chain_pulse
    );
endinterface
`default_nettype wire

//--- pri_irq_cpu_end.sv
// processor end: level enable/detect, internal traps and ident search
//
// What this block does
// - levels 10-13, 15 each own a request line
// - levels 0-9 detect set only by software
// - levels 10-13 and 15 settable by software or hardware
// - request lines feed detect register without masking
// - level 14 only from internal detect register
// - internal request needs matching internal enable bit
// - interfaces use standard level per device class
// - level 15 outranks level 14
// - ident searches one level, 10 to 13
// - present level; matching interfaces raise flag
// - chain pulse stops at first flagged slot
// - stopping slot returns code into accumulator
// - responder clears its own interrupt enable
// - slot nearest processor wins within level
// - each interface has selectable ident code
// - interface interrupts when ready bit set
// - pending requests ignored until system on
// - power up clears enable, detect, level
// - fault registers unblock after both reads
// - interface needs control enable bits set
// - internal enable bit 5 gates error indicator
// - end-of-operation and error request conditions
// - run highest level enabled and detected
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pri_irq_cpu_end
    import pri_irq_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // register port
    input wire logic [pri_irq_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pri_irq_pkg::WORD_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [pri_irq_pkg::WORD_W-1:0] o_rdata,
    // internal trap sources
    input wire logic [pri_irq_pkg::WORD_W-1:0] i_trap_req,
    input wire logic i_parity_fault,
    input wire logic [pri_irq_pkg::WORD_W-1:0] i_parity_addr,
    // running level
    output logic [pri_irq_pkg::LEVEL_W-1:0] o_current_level,
    output logic o_level_active,
    // bus side
    pri_irq_bus_if.cpu bus
);
    import pri_irq_pkg::*;

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed
    {
        logic [WORD_W-1:0] level_enable_mask;
        logic [WORD_W-1:0] level_detect_reg;
        logic [LEVEL_W-1:0] current_level;
        logic level_active;
        logic [WORD_W-1:0] internal_enable_mask;
        logic [WORD_W-1:0] internal_detect_reg;
        logic irq_system_on;
        ident_state_t ident_state;
        logic [LEVEL_W-1:0] search_level;
        logic [WAIT_CNT_W-1:0] wait_cnt;
        logic [WORD_W-1:0] accum;
        logic [LEVEL_W-1:0] internal_cause_code;
        logic [WORD_W-1:0] parity_fault_status;
        logic [WORD_W-1:0] parity_fault_address;
        logic cause_read;
        logic status_read;
        logic [WORD_W-1:0] rdata;
    } cpu_state_t;

    cpu_state_t st_ff;
    cpu_state_t nxt_st;

    logic unblocked;
    logic [WORD_W-1:0] live_detect;

    // highest set bit wins; scan runs upward so 15 beats 14
    function automatic logic [LEVEL_W:0] top_level(
        input logic [WORD_W-1:0] vec);
        logic [LEVEL_W:0] res;
        res = '0;
        for (int i = 0; i < WORD_W; i++)
        begin
            if (vec[i])
            begin
                res = {1'b1, LEVEL_W'(i)};
            end
        end
        return res;
    endfunction

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        logic [LEVEL_W:0] pick;
        logic [LEVEL_W-1:0] cmd_level;
        pick = '0;
        cmd_level = i_wdata[LEVEL_W-1:0];
        nxt_st = st_ff;
        nxt_st.rdata = RST_WORD;
        unblocked = st_ff.cause_read && st_ff.status_read;

        // detect register: software may load any level except 14
        if (i_wr && i_addr == A_LEVEL_DETECT)
        begin
            nxt_st.level_detect_reg = i_wdata;
        end
        // request lines go straight in, and win over a clear
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (bus.irq_lines[i])
            begin
                nxt_st.level_detect_reg[line_level(SEL_W'(i))] = 1'b1;
            end
        end
        // level 14 follows the gated internal requests only
        nxt_st.level_detect_reg[LVL_INTERNAL] =
            |(st_ff.internal_detect_reg & st_ff.internal_enable_mask);

        // masks and system switch
        if (i_wr && i_addr == A_LEVEL_ENABLE)
        begin
            nxt_st.level_enable_mask = i_wdata;
        end
        if (i_wr && i_addr == A_INT_ENABLE)
        begin
            nxt_st.internal_enable_mask = i_wdata;
        end
        if (i_wr && i_addr == A_SYS_CTRL)
        begin
            nxt_st.irq_system_on = i_wdata[SYS_ON_BIT];
        end

        // internal detect: write one to clear, a new trap wins
        if (i_wr && i_addr == A_INT_DETECT)
        begin
            nxt_st.internal_detect_reg = st_ff.internal_detect_reg & ~i_wdata;
        end
        nxt_st.internal_detect_reg = nxt_st.internal_detect_reg | i_trap_req;

        // cause code and parity capture stay frozen while blocked
        pick = top_level(i_trap_req);
        if (unblocked && pick[LEVEL_W])
        begin
            nxt_st.internal_cause_code = pick[LEVEL_W-1:0];
        end
        if (i_rd && i_addr == A_PARITY_STAT)
        begin
            nxt_st.parity_fault_status[PAR_FAULT_BIT] = 1'b0;
        end
        if (i_parity_fault && unblocked)
        begin
            nxt_st.parity_fault_status[PAR_FAULT_BIT] = 1'b1;
            nxt_st.parity_fault_address = i_parity_addr;
        end
        if (i_rd && i_addr == A_CAUSE_CODE)
        begin
            nxt_st.cause_read = 1'b1;
        end
        if (i_rd && i_addr == A_PARITY_STAT)
        begin
            nxt_st.status_read = 1'b1;
        end

        // running level: nothing runs above 0 until system on
        pick = top_level(st_ff.level_enable_mask & st_ff.level_detect_reg);
        if (st_ff.irq_system_on)
        begin
            nxt_st.current_level = pick[LEVEL_W-1:0];
            nxt_st.level_active = pick[LEVEL_W];
        end
        else
        begin
            nxt_st.current_level = RST_LEVEL;
            nxt_st.level_active = 1'b0;
        end

        // ident search sequencer
        case (st_ff.ident_state)
            ID_IDLE:
            begin
                if (i_wr && i_addr == A_IDENT_CMD)
                begin
                    if (cmd_level >= LVL_IDENT_MIN && cmd_level <= LVL_IDENT_MAX)
                    begin
                        nxt_st.search_level = cmd_level;
                        nxt_st.ident_state = ID_PRESENT;
                    end
                    else
                    begin
                        // illegal level: no search, zero code
                        nxt_st.accum = RST_WORD;
                    end
                end
            end
            ID_PRESENT:
            begin
                // one cycle for the slots to settle their match flags
                nxt_st.wait_cnt = '0;
                nxt_st.ident_state = ID_PULSE;
            end
            ID_PULSE:
            begin
                if (bus.ident_ack)
                begin
                    nxt_st.accum = bus.ident_code;
                    nxt_st.ident_state = ID_IDLE;
                end
                else if (st_ff.wait_cnt == WAIT_CNT_W'(IDENT_WAIT_CYC - 1))
                begin
                    // broken or empty chain must not hang the caller
                    nxt_st.accum = RST_WORD;
                    nxt_st.ident_state = ID_IDLE;
                end
                else
                begin
                    nxt_st.wait_cnt = st_ff.wait_cnt + WAIT_CNT_W'(1);
                end
            end
            default:
            begin
                nxt_st.ident_state = ID_IDLE;
            end
        endcase

        // read data, one cycle after the strobe
        if (i_rd)
        begin
            case (i_addr)
                A_LEVEL_ENABLE: nxt_st.rdata = st_ff.level_enable_mask;
                A_LEVEL_DETECT: nxt_st.rdata = st_ff.level_detect_reg;
                A_CURRENT_LEVEL: nxt_st.rdata = WORD_W'(st_ff.current_level);
                A_INT_ENABLE: nxt_st.rdata = st_ff.internal_enable_mask;
                A_INT_DETECT: nxt_st.rdata = st_ff.internal_detect_reg;
                A_SYS_CTRL: nxt_st.rdata = WORD_W'(st_ff.irq_system_on);
                A_IDENT_CMD:
                    nxt_st.rdata = WORD_W'(st_ff.ident_state != ID_IDLE);
                A_ACCUM: nxt_st.rdata = st_ff.accum;
                A_CAUSE_CODE:
                    nxt_st.rdata = unblocked ?
                        WORD_W'(st_ff.internal_cause_code) : RST_WORD;
                A_PARITY_STAT:
                    nxt_st.rdata = unblocked ?
                        st_ff.parity_fault_status : RST_WORD;
                A_PARITY_ADDR:
                    nxt_st.rdata = unblocked ?
                        st_ff.parity_fault_address : RST_WORD;
                default: nxt_st.rdata = RST_WORD;
            endcase
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            // every field resets to zero except the one-hot idle state
            st_ff <= '0;
            st_ff.ident_state <= ID_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign live_detect = st_ff.level_detect_reg;
    assign o_rdata = st_ff.rdata;
    assign o_current_level = st_ff.current_level;
    assign o_level_active = st_ff.level_active && |live_detect;
    assign bus.search_level = st_ff.search_level;
    assign bus.search_present = st_ff.ident_state != ID_IDLE;
    assign bus.search_chain_pulse = st_ff.ident_state == ID_PULSE;

endmodule
`default_nettype wire

//--- pri_irq_io_end.sv
// i/o interface slot end: request generation, match flag, chain link
`timescale 1ns/10ps
`default_nettype none
module pri_irq_io_end
    import pri_irq_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // register port
    input wire logic [pri_irq_pkg::IO_ADDR_W-1:0] i_addr,
    input wire logic [pri_irq_pkg::WORD_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [pri_irq_pkg::WORD_W-1:0] o_rdata,
    // device status pins and thumbwheel straps
    input wire logic i_ready_for_transfer,
    input wire logic i_device_error,
    input wire logic [pri_irq_pkg::SEL_W-1:0] i_level_sel,
    input wire logic [pri_irq_pkg::WORD_W-1:0] i_ident_code,
    // backplane search chain
    input wire logic i_chain_in,
    output logic o_chain_out,
    // bus side
    pri_irq_bus_if.io bus
);
    import pri_irq_pkg::*;

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed
    {
        logic [1:0] rdy_sync;
        logic [1:0] err_sync;
        logic [SEL_W-1:0] sel_meta;
        logic [SEL_W-1:0] sel_sync;
        logic [WORD_W-1:0] code_meta;
        logic [WORD_W-1:0] code_sync;
        logic eop_en;
        logic err_en;
        logic ack;
        logic [WORD_W-1:0] code;
        logic [WORD_W-1:0] rdata;
    } io_state_t;

    io_state_t st_ff;
    io_state_t nxt_st;

    logic eop_req;
    logic err_req;
    logic irq;
    logic match;
    logic [WORD_W-1:0] status;

    // both conditions need their control enable
    assign eop_req = st_ff.rdy_sync[1] && st_ff.eop_en;
    assign err_req = st_ff.err_sync[1] && st_ff.err_en;
    assign irq = eop_req || err_req;
    assign match = bus.search_present && irq &&
        bus.search_level == line_level(st_ff.sel_sync);
    // a flagged slot swallows the pulse, so nearer slots win
    // an answering slot keeps the chain shut until the pulse drops
    assign o_chain_out = i_chain_in && !match && !st_ff.ack;
    assign status = (WORD_W'(st_ff.rdy_sync[1]) << ST_READY_BIT) |
        (WORD_W'(st_ff.err_sync[1]) << ST_ERROR_BIT);

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdy_sync = {st_ff.rdy_sync[0], i_ready_for_transfer};
        nxt_st.err_sync = {st_ff.err_sync[0], i_device_error};
        nxt_st.sel_meta = i_level_sel;
        nxt_st.sel_sync = st_ff.sel_meta;
        nxt_st.code_meta = i_ident_code;
        nxt_st.code_sync = st_ff.code_meta;
        nxt_st.ack = 1'b0;
        nxt_st.rdata = RST_WORD;
        if (i_wr && i_addr == A_IO_CTRL)
        begin
            nxt_st.eop_en = i_wdata[CTL_EOP_EN_BIT];
            nxt_st.err_en = i_wdata[CTL_ERR_EN_BIT];
        end
        if (i_chain_in && match)
        begin
            nxt_st.ack = 1'b1;
            nxt_st.code = st_ff.code_sync;
            // answering drops the cause; software must re-enable
            if (eop_req)
            begin
                nxt_st.eop_en = 1'b0;
            end
            if (err_req)
            begin
                nxt_st.err_en = 1'b0;
            end
        end
        if (i_rd)
        begin
            case (i_addr)
                A_IO_CTRL:
                    nxt_st.rdata = (WORD_W'(st_ff.eop_en) << CTL_EOP_EN_BIT) |
                        (WORD_W'(st_ff.err_en) << CTL_ERR_EN_BIT);
                A_IO_STATUS: nxt_st.rdata = status;
                default: nxt_st.rdata = RST_WORD;
            endcase
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    always_comb
    begin
        bus.irq_lines = '0;
        // straps above 3 all select the level 15 line
        bus.irq_lines[(st_ff.sel_sync > 3'h3) ? 3'h4 :
            st_ff.sel_sync] = irq;
    end
    assign bus.ident_ack = st_ff.ack;
    assign bus.ident_code = st_ff.code;
    assign o_rdata = st_ff.rdata;

endmodule
`default_nettype wire

//--- pri_irq_search_props.sv
// checker for the search bus between processor end and slots
`timescale 1ns/10ps
`default_nettype none
module pri_irq_search_props
    import pri_irq_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // bus signals
    input wire logic [pri_irq_pkg::NUM_LINES-1:0] irq_lines,
    input wire logic [pri_irq_pkg::LEVEL_W-1:0] search_level,
    input wire logic search_present,
    input wire logic search_chain_pulse,
    input wire logic ident_ack,
    input wire logic [pri_irq_pkg::WORD_W-1:0] ident_code
);
    // timeout plus margin for the state change
    localparam int T_MAX = 202;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    AST_RESET_IDLE: assert property ($rose(i_resetn) |-> !search_present)
        else $error("search active after reset");
    AST_LEVEL_RANGE: assert property (search_present |->
        search_level >= LVL_IDENT_MIN && search_level <= LVL_IDENT_MAX)
        else $error("search level out of range");
    AST_LEVEL_HELD: assert property (search_present && $past(search_present)
        |-> $stable(search_level))
        else $error("search level changed mid search");
    AST_PULSE_IN_PRESENT: assert property (search_chain_pulse |-> search_present)
        else $error("chain pulse without level");
    AST_PRESENT_FIRST: assert property ($rose(search_present) |->
        !search_chain_pulse ##1 search_chain_pulse)
        else $error("pulse not one cycle after level");
    AST_ACK_FROM_CHAIN: assert property ($rose(ident_ack) |->
        $past(search_chain_pulse))
        else $error("answer without chain pulse");
    AST_ACK_SINGLE: assert property (ident_ack |=> !ident_ack)
        else $error("answer longer than one cycle");
    AST_ACK_ENDS: assert property (ident_ack |=> !search_present)
        else $error("search not ended by answer");
    AST_TIMEOUT: assert property ($rose(search_chain_pulse) |->
        ##[1:T_MAX] !search_chain_pulse)
        else $error("search never ends");

    cover property ($rose(ident_ack));
    cover property ($fell(search_chain_pulse) && !ident_ack);
    cover property (irq_lines[4] && irq_lines[2]);
endmodule
`default_nettype wire

//--- priority_interrupt_ident_search_tb.sv
// testbench: processor end facing two chained slots
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_ident_search_tb;
    import pri_irq_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wd = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] trap = 16'h0000;
    logic pf = 1'b0;
    logic [15:0] pa = 16'h0000;
    logic [3:0] cur;
    logic act;
    logic [1:0] ia[2] = '{2'h0, 2'h0};
    logic iw[2] = '{1'b0, 1'b0};
    logic ir[2] = '{1'b0, 1'b0};
    logic [15:0] ird[2];
    logic ready_for_transfer[2] = '{1'b0, 1'b0};
    logic derr[2] = '{1'b0, 1'b0};
    logic [2:0] sel[2] = '{3'h2, 3'h2};
    logic [15:0] code[2] = '{16'h0011, 16'h0022};
    logic ch0;
    int failures = 0;
    int checks = 0;
    pri_irq_bus_if bc();
    pri_irq_bus_if b0();
    pri_irq_bus_if b1();
    always #2.5 i_clk_sys = ~i_clk_sys;
    assign bc.irq_lines = b0.irq_lines | b1.irq_lines;
    assign bc.ident_ack = b0.ident_ack | b1.ident_ack;
    assign bc.ident_code = b0.ident_ack ? b0.ident_code : b1.ident_code;
    assign b0.search_level = bc.search_level;
    assign b1.search_level = bc.search_level;
    assign b0.search_present = bc.search_present;
    assign b1.search_present = bc.search_present;
    assign b0.search_chain_pulse = bc.search_chain_pulse;
    assign b1.search_chain_pulse = bc.search_chain_pulse;
    pri_irq_cpu_end u_pri_irq_cpu_end (.i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_trap_req(trap), .i_parity_fault(pf),
        .i_parity_addr(pa), .o_current_level(cur), .o_level_active(act),
        .bus(bc.cpu));
    pri_irq_io_end u_pri_irq_io_end_0 (.i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn), .i_addr(ia[0]), .i_wdata(wd), .i_wr(iw[0]),
        .i_rd(ir[0]), .o_rdata(ird[0]), .i_ready_for_transfer(ready_for_transfer[0]),
        .i_device_error(derr[0]), .i_level_sel(sel[0]),
        .i_ident_code(code[0]), .i_chain_in(bc.search_chain_pulse),
        .o_chain_out(ch0), .bus(b0.io));
    pri_irq_io_end u_pri_irq_io_end_1 (.i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn), .i_addr(ia[1]), .i_wdata(wd), .i_wr(iw[1]),
        .i_rd(ir[1]), .o_rdata(ird[1]), .i_ready_for_transfer(ready_for_transfer[1]),
        .i_device_error(derr[1]), .i_level_sel(sel[1]),
        .i_ident_code(code[1]), .i_chain_in(ch0), .o_chain_out(),
        .bus(b1.io));
    pri_irq_search_props u_pri_irq_search_props (.i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn), .irq_lines(bc.irq_lines),
        .search_level(bc.search_level), .search_present(bc.search_present),
        .search_chain_pulse(bc.search_chain_pulse),
        .ident_ack(bc.ident_ack), .ident_code(bc.ident_code));

    task chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task cpu_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
    endtask
    task cpu_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task cpu_rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        cpu_rd(a, d);
        chk(d & m, e);
    endtask
    task io_wr(input int s, input logic [1:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        ia[s] <= a;
        wd <= d;
        iw[s] <= 1'b1;
        @(posedge i_clk_sys);
        iw[s] <= 1'b0;
    endtask
    task io_rc(input int s, input logic [1:0] a, input logic [15:0] e);
        @(posedge i_clk_sys);
        ia[s] <= a;
        ir[s] <= 1'b1;
        @(posedge i_clk_sys);
        ir[s] <= 1'b0;
        #1 chk(ird[s], e);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task lvl(input logic [15:0] e);
        wait_cyc(6);
        chk(16'(cur), e);
        chk(16'(act), 16'(e != 16'h0000));
    endtask
    // busy poll is bounded beyond the search timeout
    task ident(input logic [15:0] lv, input logic [15:0] e);
        logic [15:0] d;
        int n;
        cpu_wr(A_IDENT_CMD, lv);
        d = 16'h0001;
        n = 0;
        while (d[0] !== 1'b0 && n < 300)
        begin
            cpu_rd(A_IDENT_CMD, d);
            n++;
        end
        cpu_rc(A_ACCUM, 16'hFFFF, e);
    endtask
    task t_reset;
        cpu_rc(A_LEVEL_ENABLE, 16'hFFFF, 16'h0000);
        cpu_rc(A_LEVEL_DETECT, 16'hFFFF, 16'h0000);
        cpu_rc(A_CURRENT_LEVEL, 16'hFFFF, 16'h0000);
    endtask
    task t_soft;
        cpu_wr(A_LEVEL_ENABLE, 16'h0201);
        cpu_wr(A_LEVEL_DETECT, 16'h0201);
        lvl(16'h0000);
        cpu_wr(A_SYS_CTRL, 16'h0001);
        lvl(16'h0009);
        cpu_rc(A_LEVEL_DETECT, 16'hFFFF, 16'h0201);
    endtask
    task t_line;
        ready_for_transfer[0] <= 1'b1;
        ready_for_transfer[1] <= 1'b1;
        wait_cyc(6);
        cpu_rc(A_LEVEL_DETECT, 16'h1000, 16'h0000);
        io_wr(0, A_IO_CTRL, 16'h0001);
        io_wr(1, A_IO_CTRL, 16'h0001);
        wait_cyc(6);
        cpu_rc(A_LEVEL_DETECT, 16'h1000, 16'h1000);
        cpu_wr(A_LEVEL_ENABLE, 16'hD201);
        lvl(16'h000C);
    endtask
    task t_ident;
        ident(16'h000C, 16'h0011);
        io_rc(0, A_IO_CTRL, 16'h0000);
        ident(16'h000C, 16'h0022);
        ident(16'h000C, 16'h0000);
        io_wr(0, A_IO_CTRL, 16'h0001);
        ident(16'h000D, 16'h0000);
        ident(16'h0009, 16'h0000);
    endtask
    task t_high;
        @(posedge i_clk_sys);
        trap <= 16'h0008;
        @(posedge i_clk_sys);
        trap <= 16'h0000;
        cpu_rc(A_LEVEL_DETECT, 16'h4000, 16'h0000);
        cpu_rc(A_INT_DETECT, 16'hFFFF, 16'h0008);
        cpu_rc(A_CAUSE_CODE, 16'hFFFF, 16'h0000);
        cpu_wr(A_INT_ENABLE, 16'h0008);
        lvl(16'h000E);
        sel[1] <= 3'h4;
        derr[1] <= 1'b1;
        io_wr(1, A_IO_CTRL, 16'h0002);
        lvl(16'h000F);
    endtask
    task t_fault;
        cpu_rc(A_PARITY_STAT, 16'hFFFF, 16'h0000);
        @(posedge i_clk_sys);
        trap <= 16'h0020;
        pf <= 1'b1;
        pa <= 16'h1234;
        @(posedge i_clk_sys);
        trap <= 16'h0000;
        pf <= 1'b0;
        cpu_rc(A_CAUSE_CODE, 16'hFFFF, 16'h0005);
        cpu_rc(A_PARITY_ADDR, 16'hFFFF, 16'h1234);
        cpu_rc(A_PARITY_STAT, 16'h0001, 16'h0001);
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        wait_cyc(3);
        i_resetn <= 1'b1;
        t_reset;
        t_soft;
        t_line;
        t_ident;
        t_high;
        t_fault;
        print_verdict;
    end
    // about twenty times the expected run
    initial
    begin
        #60000;
        failures++;
        print_verdict;
    end
endmodule
`default_nettype wire
